/* File: include/bds_pkg.sv */
// Functional notes
// - Read and write ports work concurrently
// - Read latency two cycles with loop on
// - Every transfer is a two-beat ascending burst
// - Operations start on true clock rise
// - True rise captures read address, selects, beat0
// - Comp rise captures write address, beat1 and its mask
// - Per-beat byte masks gate each lane
// - Write data buffered ahead of write address
// - Beat0 out on second comp rise
// - Beat1 out on third true rise
// - Echo clocks toggle with read data
// - Valid indicator marks burst data on outputs
// - Loop disabled gives one-cycle read latency
// - Address ignored when neither port selected
package bds_pkg;
  // Link geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = DATA_W / LANES;
  localparam int BURST_LEN = 2;
  // Clock of both ends; one link half period per clock
  localparam int CLK_PERIOD_NS = 100;
  // Read latency in link cycles; each is two clock cycles
  localparam int LAT_CYC_DLL_ON = 2;
  localparam int LAT_CYC_DLL_OFF = 1;
  // Pipe stage that feeds beat0; beat1 follows one stage later
  localparam int STAGE_B0_ON = 2 * LAT_CYC_DLL_ON - 2;
  localparam int STAGE_B0_OFF = 2 * LAT_CYC_DLL_OFF - 2;
  localparam int PIPE_DEPTH = STAGE_B0_ON + BURST_LEN;
endpackage : bds_pkg

/* File: include/bds_link_if.sv */
interface bds_link_if;
  import bds_pkg::*;
  // Input clock pair from the controller
  logic k;
  logic k_n;
  // Command, address and write data
  logic read_sel_n;
  logic write_sel_n;
  logic [ADDR_W-1:0] sync_address_in;
  logic [DATA_W-1:0] data_in;
  logic [LANES-1:0] byte_write_mask_n;
  logic loop_disable_n;
  // Read return path
  logic [DATA_W-1:0] data_out;
  logic echo_clock_true;
  logic echo_clock_comp;
  logic read_output_valid;

  modport dev (
    input k, k_n, read_sel_n, write_sel_n, sync_address_in, data_in,
    input byte_write_mask_n, loop_disable_n,
    output data_out, echo_clock_true, echo_clock_comp, read_output_valid
  );
  modport host (
    output k, k_n, read_sel_n, write_sel_n, sync_address_in, data_in,
    output byte_write_mask_n, loop_disable_n,
    input data_out, echo_clock_true, echo_clock_comp, read_output_valid
  );
endinterface : bds_link_if

/* File: verilog/bds_sram_device.sv */
module bds_sram_device #(
  parameter int ADDR_W = bds_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link to the controller
  bds_link_if.dev link,
  // Status
  output logic dll_bypass_o
);
  import bds_pkg::*;

  // Lane merge: low mask bit writes that lane
  function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0] mask_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!mask_n[l]) begin
        res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  // Two words per burst address
  logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

  // Clock pair edge detect and the command strobes it qualifies
  logic k_prev_q;
  logic kn_prev_q;
  logic k_rise;
  logic kn_rise;
  logic rd_take;
  logic wr_take;
  // Write buffer: both beats, their masks and the late write address
  logic wr_cmd_q;
  logic [DATA_W-1:0] wb_d0_q;
  logic [DATA_W-1:0] wb_d1_q;
  logic [LANES-1:0] wb_m0_q;
  logic [LANES-1:0] wb_m1_q;
  logic [ADDR_W-1:0] wb_addr_q;
  logic wb_pend_q;
  // Read pipe: a valid bit and both burst words per stage
  logic [PIPE_DEPTH-1:0] pv_q;
  logic [DATA_W-1:0] p0_q [PIPE_DEPTH];
  logic [DATA_W-1:0] p1_q [PIPE_DEPTH];
  logic [DATA_W-1:0] rd0;
  logic [DATA_W-1:0] rd1;
  logic rd_hit;
  // Output registers and the loop mode
  logic [DATA_W-1:0] data_out_q;
  logic valid_q;
  logic echo_t_q;
  logic echo_c_q;
  logic bypass_q;
  int s0;

  // Edge detect of the clock pair seen as sampled levels; each history
  // bit resets to its pin's idle level, so reset leaves no false rise
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      k_prev_q <= 1'b0;
      kn_prev_q <= 1'h1;
    end else begin
      k_prev_q <= link.k;
      kn_prev_q <= link.k_n;
    end
  end
  assign k_rise = link.k & ~k_prev_q;
  assign kn_rise = link.k_n & ~kn_prev_q;
  assign rd_take = k_rise & ~link.read_sel_n;
  assign wr_take = k_rise & ~link.write_sel_n;

  // Write buffer: beat0 and its mask on true rise, rest on comp rise;
  // it lets the data run half a cycle ahead of its address
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_cmd_q <= 1'b0;
      wb_pend_q <= 1'b0;
      wb_d0_q <= '0;
      wb_d1_q <= '0;
      wb_m0_q <= '1;
      wb_m1_q <= '1;
      wb_addr_q <= '0;
    end else begin
      if (k_rise) begin
        wr_cmd_q <= wr_take;
        wb_pend_q <= 1'b0; // Committed below on this same edge
        if (wr_take) begin
          wb_d0_q <= link.data_in;
          wb_m0_q <= link.byte_write_mask_n;
        end
      end else if (kn_rise && wr_cmd_q) begin
        wb_addr_q <= link.sync_address_in;
        wb_d1_q <= link.data_in;
        wb_m1_q <= link.byte_write_mask_n;
        wb_pend_q <= 1'b1;
        wr_cmd_q <= 1'b0;
      end
    end
  end

  // Commit the pending burst at the next true rise, ascending words;
  // until then reads see the held words through forwarding
  always_ff @(posedge clock_i) begin
    if (k_rise && wb_pend_q && !rst_i) begin
      mem[{wb_addr_q, 1'b0}] <= merge_lanes(mem[{wb_addr_q, 1'b0}], wb_d0_q, wb_m0_q);
      mem[{wb_addr_q, 1'b1}] <= merge_lanes(mem[{wb_addr_q, 1'b1}], wb_d1_q, wb_m1_q);
    end
  end

  // Array read with forwarding from the buffer not yet committed;
  // only a burst whose address is already known can be forwarded
  always_comb begin
    rd_hit = wb_pend_q && (wb_addr_q == link.sync_address_in);
    rd0 = mem[{link.sync_address_in, 1'b0}];
    rd1 = mem[{link.sync_address_in, 1'b1}];
    if (rd_hit) begin
      rd0 = merge_lanes(rd0, wb_d0_q, wb_m0_q);
      rd1 = merge_lanes(rd1, wb_d1_q, wb_m1_q);
    end
  end

  // Read pipe, independent of the write side, so a read and a write
  // taken on one edge never wait for each other
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pv_q <= '0;
    end else begin
      pv_q <= {pv_q[PIPE_DEPTH-2:0], rd_take};
    end
  end

  // Burst words enter at stage 0 and shift one stage a clock;
  // the valid bits and the loop mode decide which stage leaves
  always_ff @(posedge clock_i) begin
    if (rd_take) begin
      p0_q[0] <= rd0;
      p1_q[0] <= rd1;
    end
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      p0_q[i] <= p0_q[i-1];
      p1_q[i] <= p1_q[i-1];
    end
  end

  // Stage that feeds beat0 in each loop mode; beat1 leaves one stage later
  function automatic int b0_stage(input logic bypass);
    int stage;
    stage = STAGE_B0_ON;
    if (bypass) begin
      stage = STAGE_B0_OFF;
    end
    return stage;
  endfunction : b0_stage

  // Loop mode follows the disable pin; low bypasses the loop.
  // No lock wait is kept: the new latency applies one clock after the pin
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= ~link.loop_disable_n;
    end
  end
  assign s0 = b0_stage(bypass_q);

  // Valid marks each beat on the data outputs, in step with the echoes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= pv_q[s0] | pv_q[s0+1];
    end
  end

  // Output register: beat0 on a comp phase, beat1 on the true phase after;
  // between bursts it keeps the last beat rather than returning to zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_out_q <= '0;
    end else if (pv_q[s0]) begin
      data_out_q <= p0_q[s0];
    end else if (pv_q[s0+1]) begin
      data_out_q <= p1_q[s0+1];
    end
  end

  // Echo clocks run free, in phase with the output register updates;
  // free running lets the controller track phase between bursts
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      echo_t_q <= 1'b0;
      echo_c_q <= 1'b0;
    end else begin
      echo_t_q <= link.k;
      echo_c_q <= link.k_n;
    end
  end

  // Link and status outputs come straight from the registers above
  assign link.data_out = data_out_q;
  assign link.read_output_valid = valid_q;
  assign link.echo_clock_true = echo_t_q;
  assign link.echo_clock_comp = echo_c_q;
  assign dll_bypass_o = bypass_q;
endmodule : bds_sram_device

/* File: verilog/bds_sram_host.sv */
module bds_sram_host #(
  parameter int ADDR_W = bds_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Command side, taken while cmd_ready_o is high
  output logic cmd_ready_o,
  input wire logic rd_req_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic wr_req_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [bds_pkg::DATA_W-1:0] wr_data0_i,
  input wire logic [bds_pkg::DATA_W-1:0] wr_data1_i,
  input wire logic [bds_pkg::LANES-1:0] wr_mask0_n_i,
  input wire logic [bds_pkg::LANES-1:0] wr_mask1_n_i,
  input wire logic dll_enable_i,
  // Read return
  output logic rd_valid_o,
  output logic [bds_pkg::DATA_W-1:0] rd_data0_o,
  output logic [bds_pkg::DATA_W-1:0] rd_data1_o,
  // Link to the memory
  bds_link_if.host link
);
  import bds_pkg::*;

  logic k_q, ready_q, rsel_n_q, wsel_n_q, doff_n_q, wr_hold_q;
  logic [ADDR_W-1:0] addr_q, wr_addr_hold_q;
  logic [DATA_W-1:0] din_q, d1_hold_q;
  logic [LANES-1:0] mask_q, m1_hold_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] rd0_q, rd1_q;

  // Link clock divider; the command half of the period is k high
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      k_q <= 1'b0;
      ready_q <= 1'b1;
      doff_n_q <= 1'b1;
    end else begin
      k_q <= ~k_q;
      ready_q <= k_q; // High exactly when the next edge is a true rise
      doff_n_q <= dll_enable_i;
    end
  end

  // Drive command on true rise, write address and beat1 on comp rise
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rsel_n_q <= 1'b1;
      wsel_n_q <= 1'b1;
      wr_hold_q <= 1'b0;
      addr_q <= '0;
      din_q <= '0;
      mask_q <= '1;
      wr_addr_hold_q <= '0;
      d1_hold_q <= '0;
      m1_hold_q <= '1;
    end else if (!k_q) begin
      rsel_n_q <= ~rd_req_i;
      wsel_n_q <= ~wr_req_i;
      addr_q <= rd_addr_i;
      din_q <= wr_data0_i;
      mask_q <= wr_mask0_n_i;
      wr_hold_q <= wr_req_i;
      wr_addr_hold_q <= wr_addr_i;
      d1_hold_q <= wr_data1_i;
      m1_hold_q <= wr_mask1_n_i;
    end else begin
      rsel_n_q <= 1'b1;
      wsel_n_q <= 1'b1;
      if (wr_hold_q) begin
        addr_q <= wr_addr_hold_q;
        din_q <= d1_hold_q;
        mask_q <= m1_hold_q;
      end
    end
  end

  // Gather the two beats of a read burst by echo phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd0_q <= '0;
      rd1_q <= '0;
    end else begin
      rd_valid_q <= 1'b0;
      if (link.read_output_valid && link.echo_clock_comp) begin
        rd0_q <= link.data_out;
      end
      if (link.read_output_valid && link.echo_clock_true) begin
        rd1_q <= link.data_out;
        rd_valid_q <= 1'b1;
      end
    end
  end

  assign link.k = k_q;
  assign link.k_n = ~k_q;
  assign link.read_sel_n = rsel_n_q;
  assign link.write_sel_n = wsel_n_q;
  assign link.sync_address_in = addr_q;
  assign link.data_in = din_q;
  assign link.byte_write_mask_n = mask_q;
  assign link.loop_disable_n = doff_n_q;
  assign cmd_ready_o = ready_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_data0_o = rd0_q;
  assign rd_data1_o = rd1_q;
endmodule : bds_sram_host

/* File: dv/bds_link_asserts.sv */
module bds_link_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link signals watched
  input wire logic k,
  input wire logic k_n,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic loop_disable_n,
  input wire logic echo_clock_true,
  input wire logic echo_clock_comp,
  input wire logic read_output_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Beat0 rides the comp echo, beat1 the true echo
  a_read_lat_on: assert property (!read_sel_n && k && loop_disable_n |->
    ##4 (read_output_valid && echo_clock_comp) ##1 (read_output_valid && echo_clock_true))
    else $error("read burst off time with loop on");
  a_read_lat_off: assert property (!read_sel_n && k && !loop_disable_n |->
    ##2 read_output_valid[*2]) else $error("read burst off time with loop bypassed");
  a_valid_cause: assert property ($rose(read_output_valid) |->
    !$past(read_sel_n, 4) || !$past(read_sel_n, 2)) else $error("valid without a read");
  a_burst_two: assert property ($fell(read_output_valid) |->
    $past(read_output_valid, 2)) else $error("valid burst shorter than two beats");
  // Echo clocks trail the input pair by one clock
  a_echo_true: assert property (!$past(rst_i) |-> echo_clock_true == $past(k))
    else $error("true echo out of step");
  a_echo_comp: assert property (!$past(rst_i) |-> echo_clock_comp == $past(k_n))
    else $error("comp echo out of step");
  a_clock_pair: assert property (!$past(rst_i) |-> k_n == !k && k != $past(k))
    else $error("clock pair not complementary or not toggling");
  a_rsel_phase: assert property (!read_sel_n |-> k ##1 read_sel_n)
    else $error("read select outside true half");
  a_wsel_phase: assert property (!write_sel_n |-> k ##1 write_sel_n)
    else $error("write select outside true half");
  // Main scenarios
  c_concurrent: cover property (!read_sel_n && !write_sel_n);
  c_bypass_read: cover property (!read_sel_n && k && !loop_disable_n);
  c_burst_end: cover property ($fell(read_output_valid));
endmodule : bds_link_asserts

/* File: dv/bds_sram_bench.sv */
module bds_sram_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bds_pkg::*;
  localparam int LIMIT = 2000;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic rd_req_i = 1'h0;
  logic wr_req_i = 1'h0;
  logic dll_enable_i = 1'h1;
  logic cmd_ready_o, rd_valid_o, dll_bypass_o;
  logic [ADDR_W-1:0] rd_addr_i = '0;
  logic [ADDR_W-1:0] wr_addr_i = '0;
  logic [DATA_W-1:0] wr_data0_i = '0;
  logic [DATA_W-1:0] wr_data1_i = '0;
  logic [LANES-1:0] wr_mask0_n_i = '1;
  logic [LANES-1:0] wr_mask1_n_i = '1;
  logic [DATA_W-1:0] rd_data0_o, rd_data1_o, exp0, exp1;
  logic [DATA_W-1:0] model_q [logic [ADDR_W:0]];
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  bds_link_if link_if ();
  bds_sram_device bds_sram_device_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link_if),
    .dll_bypass_o(dll_bypass_o));
  bds_sram_host bds_sram_host_inst (.clock_i(clock_i), .rst_i(rst_i),
    .cmd_ready_o(cmd_ready_o), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
    .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i), .wr_data0_i(wr_data0_i),
    .wr_data1_i(wr_data1_i), .wr_mask0_n_i(wr_mask0_n_i), .wr_mask1_n_i(wr_mask1_n_i),
    .dll_enable_i(dll_enable_i), .rd_valid_o(rd_valid_o), .rd_data0_o(rd_data0_o),
    .rd_data1_o(rd_data1_o), .link(link_if));
  bds_link_asserts bds_link_asserts_inst (.clock_i(clock_i), .rst_i(rst_i), .k(link_if.k),
    .k_n(link_if.k_n), .read_sel_n(link_if.read_sel_n), .write_sel_n(link_if.write_sel_n),
    .loop_disable_n(link_if.loop_disable_n), .echo_clock_true(link_if.echo_clock_true),
    .echo_clock_comp(link_if.echo_clock_comp),
    .read_output_valid(link_if.read_output_valid));

  // Clock and hang guard
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("unexpected at %0t ns: run hung", $time);
      close_out();
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask : check

  // Lanes with a low mask bit take the new byte
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w, new_w,
                                               input logic [LANES-1:0] m_n);
    merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!m_n[i]) merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
    end
  endfunction : merge

  // Read expectation is taken before the write lands: same-slot reads see old data
  task automatic issue(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                       input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d0, d1,
                       input logic [LANES-1:0] m0, m1);
    do @(negedge clock_i); while (cmd_ready_o !== 1'h1);
    {rd_req_i, rd_addr_i, wr_req_i, wr_addr_i} = {rd, ra, wr, wa};
    {wr_data0_i, wr_data1_i, wr_mask0_n_i, wr_mask1_n_i} = {d0, d1, m0, m1};
    if (rd) {exp0, exp1} = {model_q[{ra, 1'h0}], model_q[{ra, 1'h1}]};
    if (wr) model_q[{wa, 1'h0}] = merge(model_q[{wa, 1'h0}], d0, m0);
    if (wr) model_q[{wa, 1'h1}] = merge(model_q[{wa, 1'h1}], d1, m1);
    @(negedge clock_i);
    rd_req_i = 1'h0;
    wr_req_i = 1'h0;
  endtask : issue

  // Negedges from the taking edge: capture, two halves per link cycle, gather
  task automatic result();
    int n;
    int lat;
    n = 0;
    lat = dll_enable_i ? LAT_CYC_DLL_ON : LAT_CYC_DLL_OFF;
    while (rd_valid_o !== 1'h1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    check(DATA_W'(rd_valid_o), DATA_W'(1'h1), "no read answer");
    check(DATA_W'(n), DATA_W'(2 * lat + 2), "read latency");
    check(rd_data0_o, exp0, "first beat");
    check(rd_data1_o, exp1, "second beat");
    @(negedge clock_i);
  endtask : result

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 1'h0;
    // Write then read at once, so the read hits the pending buffer
    issue(1'h0, 20'h0, 1'h1, 20'h00010, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
    issue(1'h1, 20'h00010, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    issue(1'h1, 20'h00010, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    $display("test burst done");
    // Different lanes per beat
    issue(1'h0, 20'h0, 1'h1, 20'h00010, 36'h5a5a5a5a5, 36'h0f0f0f0f0, 4'h5, 4'ha);
    issue(1'h1, 20'h00010, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    $display("test mask done");
    // Read and write in one slot, top address
    issue(1'h1, 20'h00010, 1'h1, 20'hfffff, 36'h000000001, 36'hfffffffff, 4'h0, 4'h0);
    result();
    issue(1'h1, 20'hfffff, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    $display("test concurrent done");
    // Loop bypassed; settle before reading
    dll_enable_i = 1'h0;
    repeat (4) @(negedge clock_i);
    check(DATA_W'(dll_bypass_o), DATA_W'(1'h1), "loop not bypassed");
    issue(1'h1, 20'hfffff, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    dll_enable_i = 1'h1;
    repeat (4) @(negedge clock_i);
    check(DATA_W'(dll_bypass_o), DATA_W'(1'h0), "loop still bypassed");
    issue(1'h1, 20'h00010, 1'h0, 20'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    result();
    $display("test bypass done");
    close_out();
  end
endmodule : bds_sram_bench
